// ### hpdc_consts.svh
`ifndef HPDC_CONSTS_SVH
`define HPDC_CONSTS_SVH

// ==========================================================
// Register offsets
`define HPDC_OFS_BUS_MAX_POWER   8'h0D
`define HPDC_OFS_CUR_SELF        8'h0E
`define HPDC_OFS_CUR_BUS         8'h0F
`define HPDC_OFS_PWR_GOOD_TIME   8'h10
`define HPDC_OFS_LANG_HIGH       8'h11
`define HPDC_OFS_LANG_LOW        8'h12
`define HPDC_OFS_MAKER_LEN       8'h13
`define HPDC_OFS_PRODUCT_LEN     8'h14
`define HPDC_OFS_SERIAL_LEN      8'h15

// ==========================================================
// Reset values
`define HPDC_RST_CUR_SELF        8'h02
`define HPDC_RST_CUR_BUS         8'h64
`define HPDC_RST_LANG_HIGH       8'h04
`define HPDC_RST_LANG_LOW        8'h09
`define HPDC_RST_TEXT_LEN        8'h00
`define HPDC_RST_BYTE            8'h00
`define HPDC_UNMAPPED_READ       8'h00

// ==========================================================
// Language table descriptor layout
`define HPDC_LANG_DESC_LEN       8'h04
`define HPDC_STRING_DESC_TYPE    8'h03
`define HPDC_LANG_LAST_IDX       2'h3
`define HPDC_IDX_LEN             2'h0
`define HPDC_IDX_TYPE            2'h1
`define HPDC_IDX_LOW             2'h2

`endif

// ### hpdc_pkg.sv
`default_nettype none
package hpdc_pkg;

  // ========================================================
  // Register file
  typedef struct packed {
    logic [7:0] bus_powered_max_power;
    logic [7:0] controller_current_self_powered;
    logic [7:0] controller_current_bus_powered;
    logic [7:0] power_on_to_good_time;
    logic [7:0] language_id_high;
    logic [7:0] language_id_low;
    logic [7:0] maker_string_length;
    logic [7:0] product_name_length;
    logic [7:0] serial_number_length;
  } hpdc_regs_t;

  // ========================================================
  // Register access from the serial slave port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } hpdc_reg_req_t;

  // ========================================================
  // Descriptor fields handed to the descriptor engine
  typedef struct packed {
    logic        bus_powered;
    logic [7:0]  bus_powered_power_units;
    logic [7:0]  controller_current_units;
    logic [7:0]  power_good_time_units;
    logic [15:0] language_code;
    logic [7:0]  maker_text_length;
    logic [7:0]  product_text_length;
    logic [7:0]  serial_text_length;
  } hpdc_desc_t;

  typedef enum logic {
    HPDC_SER_IDLE,
    HPDC_SER_SEND
  } hpdc_ser_state_t;

  typedef struct packed {
    hpdc_ser_state_t state;
    logic [1:0]      idx;
    logic [7:0]      data;
    logic            valid;
    logic            last;
  } hpdc_ser_t;

  typedef struct packed {
    hpdc_regs_t regs;
    logic       self_meta;
    logic       self_sync;
    logic [7:0] rdata;
    logic       rvalid;
    hpdc_desc_t desc;
  } hpdc_top_t;

endpackage : hpdc_pkg
`default_nettype wire

// ### hpdc_lang_ser.sv
`timescale 1ns/10ps
`default_nettype none
`include "hpdc_consts.svh"

module hpdc_lang_ser (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [15:0] lang_code,
  output var  logic [7:0]  byte_data,
  output var  logic        byte_valid,
  output var  logic        byte_last
);
  import hpdc_pkg::*;

  hpdc_ser_t s_q;
  hpdc_ser_t s_d;

  // ========================================================
  // Byte selection, code units go out low byte first
  function automatic logic [7:0] pick(input logic [1:0] i, input logic [15:0] code);
    logic [7:0] b;
    b = code[15:8];                                   // R11
    if (i == `HPDC_IDX_LEN) begin
      b = `HPDC_LANG_DESC_LEN;
    end else if (i == `HPDC_IDX_TYPE) begin
      b = `HPDC_STRING_DESC_TYPE;
    end else if (i == `HPDC_IDX_LOW) begin
      b = code[7:0];                                  // R11
    end
    return b;
  endfunction : pick

  // ========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    if (ce) begin
      case (s_q.state)
        HPDC_SER_IDLE: begin
          s_d.valid = 1'b0;
          s_d.last  = 1'b0;
          if (start) begin
            s_d.state = HPDC_SER_SEND;
            s_d.idx   = `HPDC_IDX_TYPE;
            s_d.data  = pick(`HPDC_IDX_LEN, lang_code);
            s_d.valid = 1'b1;
          end
        end
        HPDC_SER_SEND: begin
          // Code is sampled per byte, a rewrite mid-stream shows up
          s_d.data = pick(s_q.idx, lang_code);
          s_d.last = (s_q.idx == `HPDC_LANG_LAST_IDX);
          s_d.idx  = s_q.idx + 2'h1;
          if (s_q.idx == `HPDC_LANG_LAST_IDX) begin
            s_d.state = HPDC_SER_IDLE;
          end
        end
        default: begin
          s_d.state = HPDC_SER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{state: HPDC_SER_IDLE, idx: 2'h0, data: `HPDC_RST_BYTE, valid: 1'b0, last: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign byte_data  = s_q.data;
  assign byte_valid = s_q.valid;
  assign byte_last  = s_q.last;

endmodule : hpdc_lang_ser
`default_nettype wire

// ### hpdc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "hpdc_consts.svh"

// Behaviour
// R1: Bus max power reported in 2 mA units
// R2: Master includes board and zero-current function
// R3: Self-powered controller current 1 mA, reset 2
// R4: Master excludes embedded function from currents
// R5: Master keeps self-powered current at most 100
// R6: Bus-powered controller current 1 mA, reset 100
// R7: Power-good time only feeds hub descriptor
// R8: Master writes zero without power switch
// R9: Language code is high:low, reset 0x0409
// R10: Three text lengths, each resets to zero
// R11: Code units little-endian, low byte first
// R12: Controller current follows current power mode
module hpdc_top #(
  parameter logic [7:0] BUS_MAX_POWER_RESET = 8'h01,
  parameter logic [7:0] PWR_GOOD_TIME_RESET = 8'h01
) (
  input  wire logic                 MCLK,
  input  wire logic                 ARST_N,
  input  wire logic                 CE,
  input  wire hpdc_pkg::hpdc_reg_req_t REG_REQ,
  output var  logic [7:0]           REG_RDATA,
  output var  logic                 REG_RVALID,
  input  wire logic                 SELF_POWERED,
  output var  hpdc_pkg::hpdc_desc_t DESC,
  input  wire logic                 LANG_START,
  output var  logic [7:0]           LANG_BYTE,
  output var  logic                 LANG_VALID,
  output var  logic                 LANG_LAST
);
  import hpdc_pkg::*;

  hpdc_top_t t_q;
  hpdc_top_t t_d;

  // ========================================================
  // Register read decode
  function automatic logic [7:0] read_reg(input logic [7:0] a, input hpdc_regs_t r);
    logic [7:0] v;
    v = `HPDC_UNMAPPED_READ;
    if (a == `HPDC_OFS_BUS_MAX_POWER) begin
      v = r.bus_powered_max_power;
    end else if (a == `HPDC_OFS_CUR_SELF) begin
      v = r.controller_current_self_powered;
    end else if (a == `HPDC_OFS_CUR_BUS) begin
      v = r.controller_current_bus_powered;
    end else if (a == `HPDC_OFS_PWR_GOOD_TIME) begin
      v = r.power_on_to_good_time;
    end else if (a == `HPDC_OFS_LANG_HIGH) begin
      v = r.language_id_high;
    end else if (a == `HPDC_OFS_LANG_LOW) begin
      v = r.language_id_low;
    end else if (a == `HPDC_OFS_MAKER_LEN) begin
      v = r.maker_string_length;
    end else if (a == `HPDC_OFS_PRODUCT_LEN) begin
      v = r.product_name_length;
    end else if (a == `HPDC_OFS_SERIAL_LEN) begin
      v = r.serial_number_length;
    end
    return v;
  endfunction : read_reg

  // ========================================================
  // Next state
  always_comb begin
    t_d = t_q;
    if (CE) begin
      // Power mode strap comes from a pin
      t_d.self_meta = SELF_POWERED;
      t_d.self_sync = t_q.self_meta;
      t_d.rvalid    = REG_REQ.rd;
      if (REG_REQ.rd) begin
        t_d.rdata = read_reg(REG_REQ.addr, t_q.regs);
      end
      // Writes land one cycle later; unmapped writes vanish
      if (REG_REQ.wr) begin
        if (REG_REQ.addr == `HPDC_OFS_BUS_MAX_POWER) begin
          t_d.regs.bus_powered_max_power = REG_REQ.wdata;          // R1
        end else if (REG_REQ.addr == `HPDC_OFS_CUR_SELF) begin
          t_d.regs.controller_current_self_powered = REG_REQ.wdata; // R3
        end else if (REG_REQ.addr == `HPDC_OFS_CUR_BUS) begin
          t_d.regs.controller_current_bus_powered = REG_REQ.wdata;  // R6
        end else if (REG_REQ.addr == `HPDC_OFS_PWR_GOOD_TIME) begin
          t_d.regs.power_on_to_good_time = REG_REQ.wdata;           // R7
        end else if (REG_REQ.addr == `HPDC_OFS_LANG_HIGH) begin
          t_d.regs.language_id_high = REG_REQ.wdata;                // R9
        end else if (REG_REQ.addr == `HPDC_OFS_LANG_LOW) begin
          t_d.regs.language_id_low = REG_REQ.wdata;                 // R9
        end else if (REG_REQ.addr == `HPDC_OFS_MAKER_LEN) begin
          t_d.regs.maker_string_length = REG_REQ.wdata;             // R10
        end else if (REG_REQ.addr == `HPDC_OFS_PRODUCT_LEN) begin
          t_d.regs.product_name_length = REG_REQ.wdata;             // R10
        end else if (REG_REQ.addr == `HPDC_OFS_SERIAL_LEN) begin
          t_d.regs.serial_number_length = REG_REQ.wdata;            // R10
        end
      end
      // Descriptor fields track the registers one cycle behind
      t_d.desc.bus_powered             = ~t_q.self_sync;
      t_d.desc.bus_powered_power_units = t_q.regs.bus_powered_max_power; // R1
      if (t_q.self_sync) begin
        t_d.desc.controller_current_units = t_q.regs.controller_current_self_powered; // R12
      end else begin
        t_d.desc.controller_current_units = t_q.regs.controller_current_bus_powered;  // R12
      end
      // Power-good time steers nothing else in the hub
      t_d.desc.power_good_time_units = t_q.regs.power_on_to_good_time; // R7
      t_d.desc.language_code = {t_q.regs.language_id_high, t_q.regs.language_id_low}; // R9
      t_d.desc.maker_text_length   = t_q.regs.maker_string_length;   // R10
      t_d.desc.product_text_length = t_q.regs.product_name_length;   // R10
      t_d.desc.serial_text_length  = t_q.regs.serial_number_length;  // R10
    end
  end

  // ========================================================
  // State register
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      t_q.regs.bus_powered_max_power          <= BUS_MAX_POWER_RESET;
      t_q.regs.controller_current_self_powered <= `HPDC_RST_CUR_SELF;  // R3
      t_q.regs.controller_current_bus_powered  <= `HPDC_RST_CUR_BUS;   // R6
      t_q.regs.power_on_to_good_time          <= PWR_GOOD_TIME_RESET;
      t_q.regs.language_id_high               <= `HPDC_RST_LANG_HIGH; // R9
      t_q.regs.language_id_low                <= `HPDC_RST_LANG_LOW;  // R9
      t_q.regs.maker_string_length            <= `HPDC_RST_TEXT_LEN;  // R10
      t_q.regs.product_name_length            <= `HPDC_RST_TEXT_LEN;  // R10
      t_q.regs.serial_number_length           <= `HPDC_RST_TEXT_LEN;  // R10
      t_q.self_meta                           <= 1'b0;
      t_q.self_sync                           <= 1'b0;
      t_q.rdata                               <= `HPDC_RST_BYTE;
      t_q.rvalid                              <= 1'b0;
      // Descriptor fields show bus-powered reset values from the start
      t_q.desc.bus_powered                    <= 1'b1;
      t_q.desc.bus_powered_power_units        <= BUS_MAX_POWER_RESET;
      t_q.desc.controller_current_units       <= `HPDC_RST_CUR_BUS;
      t_q.desc.power_good_time_units          <= PWR_GOOD_TIME_RESET;
      t_q.desc.language_code                  <= {`HPDC_RST_LANG_HIGH, `HPDC_RST_LANG_LOW};
      t_q.desc.maker_text_length              <= `HPDC_RST_TEXT_LEN;
      t_q.desc.product_text_length            <= `HPDC_RST_TEXT_LEN;
      t_q.desc.serial_text_length             <= `HPDC_RST_TEXT_LEN;
    end else begin
      t_q <= t_d;
    end
  end

  assign REG_RDATA  = t_q.rdata;
  assign REG_RVALID = t_q.rvalid;
  assign DESC       = t_q.desc;

  // ========================================================
  // Language table descriptor, code unit sent low byte first
  hpdc_lang_ser u_lang_ser (
    .clk        (MCLK),
    .arst_n     (ARST_N),
    .ce         (CE),
    .start      (LANG_START),
    .lang_code  (t_q.desc.language_code),
    .byte_data  (LANG_BYTE),
    .byte_valid (LANG_VALID),
    .byte_last  (LANG_LAST)
  );

endmodule : hpdc_top
`default_nettype wire

// ### hpdc_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checks of the descriptor register bank
module hpdc_chk (
  input wire logic                    MCLK,
  input wire logic                    ARST_N,
  input wire logic                    CE,
  input wire hpdc_pkg::hpdc_reg_req_t REG_REQ,
  input wire logic [7:0]              REG_RDATA,
  input wire logic                    REG_RVALID,
  input wire logic                    SELF_POWERED,
  input wire hpdc_pkg::hpdc_desc_t    DESC,
  input wire logic                    LANG_START,
  input wire logic [7:0]              LANG_BYTE,
  input wire logic                    LANG_VALID,
  input wire logic                    LANG_LAST
);
  import hpdc_pkg::*;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  chk_read_pulse: assert property (CE |=> REG_RVALID == $past(REG_REQ.rd))
    else $error("read valid does not follow read request");
  chk_unmapped_zero: assert property (CE && REG_REQ.rd && !(REG_REQ.addr inside
    {[8'h0D:8'h15]}) |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
  chk_bus_power: assert property (
    CE && REG_REQ.wr && REG_REQ.addr == 8'h0D ##1 CE |=>
    DESC.bus_powered_power_units == $past(REG_REQ.wdata, 2)) else $error("power units stale");
  chk_good_time: assert property (
    CE && REG_REQ.wr && REG_REQ.addr == 8'h10 ##1 CE |=>
    DESC.power_good_time_units == $past(REG_REQ.wdata, 2)) else $error("good time stale");
  chk_lang_high: assert property (
    CE && REG_REQ.wr && REG_REQ.addr == 8'h11 ##1 CE |=>
    DESC.language_code[15:8] == $past(REG_REQ.wdata, 2)) else $error("language high stale");
  chk_maker_len: assert property (
    CE && REG_REQ.wr && REG_REQ.addr == 8'h13 ##1 CE |=>
    DESC.maker_text_length == $past(REG_REQ.wdata, 2)) else $error("maker length stale");
  chk_mode_follow: assert property (
    CE && SELF_POWERED ##1 CE && SELF_POWERED ##1 CE && SELF_POWERED |=> !DESC.bus_powered)
    else $error("power mode not followed");
  chk_lang_take: assert property (CE && LANG_START && !LANG_VALID |=> LANG_VALID)
    else $error("language request not taken");
  chk_lang_order: assert property (
    $rose(LANG_VALID) |-> LANG_BYTE == 8'h04 && !LANG_LAST ##1 LANG_BYTE == 8'h03
    ##1 LANG_BYTE == $past(DESC.language_code[7:0]) && !LANG_LAST
    ##1 LANG_BYTE == $past(DESC.language_code[15:8]) && LANG_LAST
    ##1 (!LANG_VALID || LANG_BYTE == 8'h04))
    else $error("language stream order wrong");
endmodule : hpdc_chk

bind hpdc_top hpdc_chk u_chk (.MCLK(MCLK), .ARST_N(ARST_N), .CE(CE), .REG_REQ(REG_REQ),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .SELF_POWERED(SELF_POWERED),
  .DESC(DESC), .LANG_START(LANG_START), .LANG_BYTE(LANG_BYTE),
  .LANG_VALID(LANG_VALID), .LANG_LAST(LANG_LAST));
`default_nettype wire

// ### hpdc_cfg_master.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Configuration master on the register port
module hpdc_cfg_master (
  input  wire logic                    mclk,
  input  wire logic [7:0]              rdata,
  input  wire logic                    rvalid,
  output var  hpdc_pkg::hpdc_reg_req_t req
);
  import hpdc_pkg::*;
  initial req = '0;
  // Released lines show the inverse, never a stale copy
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : put
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    #1;
    d = (rvalid === 1'b1) ? rdata : 8'hXX;
  endtask : get
endmodule : hpdc_cfg_master
`default_nettype wire

// ### hpdc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Register bank bench
module hpdc_top_tb;
  import hpdc_pkg::*;
  localparam logic [7:0] MAXP0 = 8'h05;
  localparam logic [7:0] TIME0 = 8'h07;
  logic          mclk = 1'b0;
  logic          arst_n = 1'b0;
  logic          ce = 1'b1;
  logic          self_pw = 1'b0;
  logic          lang_start = 1'b0;
  hpdc_reg_req_t req;
  hpdc_desc_t    desc;
  logic [7:0]    rdata, lang_byte, rv;
  logic          rvalid, lang_valid, lang_last;
  int            n_errors = 0;
  int            tests_run = 0;
  int            cyc = 0;
  logic [7:0] rst_v [9] = '{MAXP0, 8'h02, 8'h64, TIME0, 8'h04, 8'h09, 8'h00, 8'h00, 8'h00};
  // Self current kept under 100 mA, no power switch so time is zero
  logic [7:0] new_v [9] = '{8'h32, 8'h30, 8'h50, 8'h00, 8'h08, 8'h07, 8'h0A, 8'h0C, 8'h14};
  logic [7:0] lang_v [4];

  always #2.5 mclk = ~mclk;

  hpdc_top #(.BUS_MAX_POWER_RESET(MAXP0), .PWR_GOOD_TIME_RESET(TIME0)) dut (
    .MCLK(mclk), .ARST_N(arst_n), .CE(ce), .REG_REQ(req), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .SELF_POWERED(self_pw), .DESC(desc), .LANG_START(lang_start),
    .LANG_BYTE(lang_byte), .LANG_VALID(lang_valid), .LANG_LAST(lang_last));
  hpdc_cfg_master m (.mclk(mclk), .rdata(rdata), .rvalid(rvalid), .req(req));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // Hang guard, the whole run needs under a hundred cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    chk(desc.language_code[15:8], 8'h04);
    chk(desc.language_code[7:0], 8'h09);
    chk(desc.controller_current_units, 8'h64);
    chk({7'h00, desc.bus_powered}, 8'h01);
    for (int i = 0; i < 9; i++) begin
      m.get(8'h0D + 8'(i), rv);
      chk(rv, rst_v[i]);
    end
    for (int i = 0; i < 9; i++) m.put(8'h0D + 8'(i), new_v[i]);
    for (int i = 0; i < 9; i++) begin
      m.get(8'h0D + 8'(i), rv);
      chk(rv, new_v[i]);
    end
    chk(desc.bus_powered_power_units, new_v[0]);
    chk(desc.controller_current_units, new_v[2]);
    chk(desc.power_good_time_units, new_v[3]);
    chk(desc.language_code[15:8], new_v[4]);
    chk(desc.language_code[7:0], new_v[5]);
    chk(desc.maker_text_length, new_v[6]);
    chk(desc.product_text_length, new_v[7]);
    chk(desc.serial_text_length, new_v[8]);
    @(posedge mclk);
    self_pw <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk(desc.controller_current_units, new_v[1]);
    chk({7'h00, desc.bus_powered}, 8'h00);
    lang_v = '{8'h04, 8'h03, new_v[5], new_v[4]};
    @(posedge mclk);
    lang_start <= 1'b1;
    @(posedge mclk);
    lang_start <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      #1;
      chk(lang_byte, lang_v[k]);
      chk({6'h00, lang_valid, lang_last}, {6'h00, 1'b1, 1'(k == 3)});
      @(posedge mclk);
    end
    #1;
    chk({7'h00, lang_valid}, 8'h00);
    m.get(8'h16, rv);
    chk(rv, 8'h00);
    m.put(8'h0C, 8'hAA);
    m.get(8'h0C, rv);
    chk(rv, 8'h00);
    // Frozen clock enable must swallow the write
    @(posedge mclk);
    ce <= 1'b0;
    m.put(8'h13, 8'h77);
    @(posedge mclk);
    ce <= 1'b1;
    self_pw <= 1'b0;
    m.get(8'h13, rv);
    chk(rv, new_v[6]);
    repeat (4) @(posedge mclk);
    #1;
    chk(desc.controller_current_units, new_v[2]);
    report_and_stop();
  end
endmodule : hpdc_top_tb
`default_nettype wire
